// [bench/cicr_filter_checker.sv]
// Port-level assertions for the CIC rate changer
`timescale 1ns/10ps
module cicr_filter_checker #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 19
) (
  input wire logic                   SYS_CLK,
  input wire logic                   SRST,
  input wire logic                   CE,
  input wire cicr_pkg::cicr_wb_req_t WB_REQ,
  input wire logic [31:0]            WB_DAT_O,
  input wire logic                   WB_ACK_O,
  input wire logic                   SAMPLE_IN_VALID,
  input wire logic                   SAMPLE_IN_READY,
  input wire logic [OUT_W-1:0]       SAMPLE_OUT,
  input wire logic                   SAMPLE_OUT_VALID
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  AST_ACK_TAKEN: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O && CE |=> WB_ACK_O)
    else $error("request not acknowledged in the next cycle");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_REQ.cyc && WB_REQ.stb))
    else $error("ack without a request");
  AST_UNMAPPED_ZERO: assert property (WB_ACK_O && !WB_REQ.we && WB_REQ.adr > 8'h10 |-> WB_DAT_O == 32'h0)
    else $error("unmapped read returned nonzero data");
  AST_OUT_SPACING: assert property (SAMPLE_OUT_VALID |=> !SAMPLE_OUT_VALID [*7])
    else $error("outputs closer than the rate factor");
  AST_OUT_CAUSE: assert property (SAMPLE_OUT_VALID |-> $past(SAMPLE_IN_VALID && SAMPLE_IN_READY))
    else $error("output not launched by an accepted input");
  AST_CE_READY: assert property (!CE |-> !SAMPLE_IN_READY)
    else $error("ready high while clock enable low");
  AST_CE_OUT: assert property (!CE |-> !SAMPLE_OUT_VALID)
    else $error("output valid while clock enable low");
  AST_RST_CLEAR: assert property ($fell(SRST) |-> !WB_ACK_O && !SAMPLE_OUT_VALID && SAMPLE_OUT == '0
                                  && SAMPLE_IN_READY == CE)
    else $error("state not cleared by reset");
endmodule : cicr_filter_checker

bind cicr_filter cicr_filter_checker #(.IN_W(IN_W), .OUT_W(OUT_W)) u_chk (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .CE(CE), .WB_REQ(WB_REQ), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .SAMPLE_IN_VALID(SAMPLE_IN_VALID), .SAMPLE_IN_READY(SAMPLE_IN_READY),
  .SAMPLE_OUT(SAMPLE_OUT), .SAMPLE_OUT_VALID(SAMPLE_OUT_VALID));

// [bench/cicr_filter_test.sv]
// Self-checking bench for the CIC rate changer as a decimator
`timescale 1ns/10ps
`include "cicr_map.svh"
module cicr_filter_test;
  localparam int IN_W  = 16;
  localparam int OUT_W = 19;
  logic                   sys_clk = 1'b0;
  logic                   srst    = 1'b1;
  logic                   ce      = 1'b1;
  cicr_pkg::cicr_wb_req_t wb_req  = '0;
  logic [31:0]            wb_dat;
  logic                   wb_ack;
  logic [IN_W-1:0]        sample;
  logic [IN_W-1:0]        value   = '0;
  logic [15:0]            limit   = '0;
  logic [15:0]            n_in;
  logic [15:0]            n_out;
  logic                   valid;
  logic                   ready;
  logic [OUT_W-1:0]       out_data;
  logic                   out_valid;
  logic [OUT_W-1:0]       last_out;
  int                     err_total = 0;
  int                     n_checks  = 0;
  int                     cycles    = 0;
  logic [IN_W-1:0]        vals [2]  = '{16'h0005, 16'hFFFD};
  logic [OUT_W-1:0]       outs [2]  = '{19'h00028, 19'h7FFE8};

  always #2.5 sys_clk = ~sys_clk;

  cicr_filter #(.FILTER_TYPE(cicr_pkg::CICR_DECIM), .RATE(8), .STAGES(1), .DIFF_DELAY(1), .PIPE_COMB(1'b0)) dut (
    .SYS_CLK(sys_clk), .SRST(srst), .CE(ce), .WB_REQ(wb_req), .WB_DAT_O(wb_dat), .WB_ACK_O(wb_ack),
    .SAMPLE_IN(sample), .SAMPLE_IN_VALID(valid), .SAMPLE_IN_READY(ready),
    .SAMPLE_OUT(out_data), .SAMPLE_OUT_VALID(out_valid));

  cicr_stream_model #(.IN_W(IN_W), .OUT_W(OUT_W)) u_model (
    .clk(sys_clk), .srst(srst), .value(value), .limit(limit), .ready(ready), .out_data(out_data),
    .out_valid(out_valid), .sample(sample), .valid(valid), .n_in(n_in), .n_out(n_out), .last_out(last_out));

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request stands until the edge that samples ack high; read data is taken at that same edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [31:0] msk);
    logic [31:0] rdat;
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: d};
    // Flop outputs still show their pre-edge value here, which is what the edge samples
    do
      @(posedge sys_clk);
    while (wb_ack !== 1'b1);
    rdat = wb_dat;
    wb_req <= '0;
    if (!we)
      chk(rdat & msk, d);
  endtask : wb

  task automatic wait_in(input logic [15:0] target);
    for (int n = 0; n < 400 && n_in !== target; n++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask : wait_in

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    wb(1'b0, `CICR_REG_CTRL, 32'h1, 32'h3);
    wb(1'b0, `CICR_REG_CONFIG, 32'h0101_0008, 32'hFFFF_FFFF);
    wb(1'b0, `CICR_REG_STATUS, 32'h2, 32'h3);
    wb(1'b0, 8'h20, 32'h0, 32'hFFFF_FFFF);
    wb(1'b1, `CICR_REG_STATUS, 32'h0, 32'h0);
    wb(1'b0, `CICR_REG_STATUS, 32'h2, 32'h3);
    // Positive then negative constant input; steady output is the input times R
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      value <= vals[k];
      limit <= limit + 16'h0040;
      wait_in(16'(16'h0040 * (k + 1)));
      chk(32'(last_out), 32'(outs[k]));
      chk(32'(n_out), 32'(8 * (k + 1)));
    end
    wb(1'b0, `CICR_REG_IN_CNT, 32'h80, 32'hFFFF_FFFF);
    wb(1'b0, `CICR_REG_OUT_CNT, 32'h10, 32'hFFFF_FFFF);
    // Clock enable low holds the input off
    @(posedge sys_clk);
    ce    <= 1'b0;
    limit <= limit + 16'h0010;
    repeat (10) @(posedge sys_clk);
    chk(32'(n_in), 32'h80);
    ce <= 1'b1;
    wait_in(16'h0090);
    // Run off refuses every sample
    wb(1'b1, `CICR_REG_CTRL, 32'h0, 32'h0);
    limit <= limit + 16'h0010;
    repeat (10) @(posedge sys_clk);
    chk(32'(n_in), 32'h90);
    // Clear flushes the counters and leaves run off
    wb(1'b1, `CICR_REG_CTRL, 32'h2, 32'h0);
    wb(1'b0, `CICR_REG_IN_CNT, 32'h0, 32'hFFFF_FFFF);
    wb(1'b0, `CICR_REG_OUT_CNT, 32'h0, 32'hFFFF_FFFF);
    wb(1'b0, `CICR_REG_CTRL, 32'h0, 32'h3);
    // Mid-run reset returns run to its reset value; the source is held off meanwhile
    srst  <= 1'b1;
    limit <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    wb(1'b0, `CICR_REG_CTRL, 32'h1, 32'h3);
    wrap_up();
  end
endmodule : cicr_filter_test

// [bench/cicr_stream_model.sv]
// Upstream sample source and downstream sink beside the CIC rate changer
`timescale 1ns/10ps
module cicr_stream_model #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 19
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [IN_W-1:0]  value,
  input  wire logic [15:0]      limit,
  input  wire logic             ready,
  input  wire logic [OUT_W-1:0] out_data,
  input  wire logic             out_valid,
  output logic [IN_W-1:0]       sample,
  output logic                  valid,
  output logic [15:0]           n_in,
  output logic [15:0]           n_out,
  output logic [OUT_W-1:0]      last_out
);
  // Offer until the budget is spent; idle data is inverted so it never looks valid
  assign valid  = (n_in < limit);
  assign sample = valid ? value : ~value;

  always_ff @(posedge clk)
  begin
    if (srst)
      n_in <= 16'h0000;
    else if (valid && ready)
      n_in <= n_in + 16'h0001;
  end

  // No back-pressure exists, so every output pulse is taken
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      n_out    <= 16'h0000;
      last_out <= '0;
    end
    else if (out_valid)
    begin
      n_out    <= n_out + 16'h0001;
      last_out <= out_data;
    end
  end
endmodule : cicr_stream_model

// [rtl/cicr_comb.sv]
// One comb stage: difference against a delayed copy, optionally registered
`timescale 1ns/10ps
module cicr_comb #(
  parameter int W    = 16,
  parameter int DLY  = 1,
  parameter bit PIPE = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] dly_r [DLY];
  logic [W-1:0] diff;

  // Wraparound difference is exact as long as W covers the full growth
  assign diff = in_data - dly_r[DLY-1];

  always_ff @(posedge clk)
  begin
    if (srst || (ce && clr))
    begin
      for (int i = 0; i < DLY; i++)
        dly_r[i] <= '0;
    end
    else if (ce && in_valid)
    begin
      dly_r[0] <= in_data;
      for (int i = 1; i < DLY; i++)
        dly_r[i] <= dly_r[i-1];
    end
  end

  generate
    if (PIPE)
    begin : g_pipe
      logic         v_r;
      logic [W-1:0] d_r;
      always_ff @(posedge clk)
      begin
        if (srst || (ce && clr))
        begin
          v_r <= 1'b0;
          d_r <= '0;
        end
        else if (ce)
        begin
          v_r <= in_valid;
          if (in_valid)
            d_r <= diff;
        end
      end
      assign out_valid = v_r;
      assign out_data  = d_r;
    end
    else
    begin : g_comb
      assign out_valid = in_valid;
      assign out_data  = diff;
    end
  endgenerate

endmodule : cicr_comb

// [rtl/cicr_filter.sv]
// CIC rate changer top: integrators, rate change, combs and Wishbone registers
//
// Notes on behaviour
// - Input sample width may be set anywhere from 1 to 128 bits.
// - Only adders, subtractors and registers; no multiplier in the datapath.
// - Each integrator adds the current input to its own previous output.
// - Each comb subtracts the sample R times M high-rate samples back.
// - Equal count of integrators and combs, rate change sits between them.
// - Interpolator inserts R-1 zero samples after every comb output.
// - Decimator keeps one of every R last-integrator outputs.
// - Filter type chosen at build time: interpolator or decimator.
// - Rate change factor configurable from 8 to 16384.
// - Stage pairs configurable from 1 to 32.
// - Differential delay configurable from 1 to 4.
// - Switch turns comb pipeline registers on or off.
// - Input width and binary point are build parameters.
`timescale 1ns/10ps
`include "cicr_map.svh"
module cicr_filter #(
  parameter int               IN_W        = `CICR_IN_W_DEF,
  parameter int               IN_BP       = `CICR_IN_BP_DEF,
  parameter cicr_pkg::cicr_type_t FILTER_TYPE = cicr_pkg::CICR_DECIM,
  parameter int               RATE        = `CICR_RATE_DEF,
  parameter int               STAGES      = `CICR_STAGES_DEF,
  parameter int               DIFF_DELAY  = `CICR_DLY_DEF,
  parameter bit               PIPE_COMB   = `CICR_PIPE_DEF,
  // Derived, not meant to be overridden
  parameter int               OUT_W       = IN_W + STAGES * $clog2(RATE * DIFF_DELAY)
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SRST,
  input  wire logic                  CE,
  input  wire cicr_pkg::cicr_wb_req_t WB_REQ,
  output logic [31:0]                WB_DAT_O,
  output logic                       WB_ACK_O,
  input  wire logic [IN_W-1:0]       SAMPLE_IN,
  input  wire logic                  SAMPLE_IN_VALID,
  output logic                       SAMPLE_IN_READY,
  output logic [OUT_W-1:0]           SAMPLE_OUT,
  output logic                       SAMPLE_OUT_VALID
);

  localparam int PH_W = $clog2(RATE);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(RATE - 1);
  localparam bit IS_DEC = (FILTER_TYPE == cicr_pkg::CICR_DECIM);

  // Build-time range checks: out-of-range settings stop elaboration
  generate
    if (IN_W < 1 || IN_W > 128)
    begin : g_bad_width
      $error("input width outside 1 to 128");
    end
    if (RATE < 8 || RATE > 16384)
    begin : g_bad_rate
      $error("rate factor outside 8 to 16384");
    end
    if (STAGES < 1 || STAGES > 32)
    begin : g_bad_stages
      $error("stage count outside 1 to 32");
    end
    if (DIFF_DELAY < 1 || DIFF_DELAY > 4)
    begin : g_bad_delay
      $error("differential delay outside 1 to 4");
    end
    if (IN_BP < 0 || IN_BP > IN_W)
    begin : g_bad_bp
      $error("binary point outside the input word");
    end
  endgenerate

  // Sign extension of an input-width word to the full accumulator width
  function automatic logic [OUT_W-1:0] sext(input logic [IN_W-1:0] v);
    sext = {{(OUT_W-IN_W){v[IN_W-1]}}, v};
  endfunction : sext

  // Register file state
  logic                    ack_r;
  logic [31:0]             dat_r;
  logic                    run_r;
  logic                    clr_r;
  logic [31:0]             in_cnt_r;
  logic [31:0]             out_cnt_r;
  logic                    wb_hit;
  logic                    wb_wr_ctrl;
  logic [31:0]             rd_nxt;

  // Datapath state
  logic [PH_W-1:0]         ph_r;
  logic                    busy_r;
  logic                    up_act_r;
  logic [OUT_W-1:0]        up_hold_r;
  logic                    fire_d_r;
  logic [OUT_W-1:0]        integ_r [STAGES];
  logic [OUT_W-1:0]        out_r;
  logic                    out_v_r;

  logic                    in_fire;
  logic                    int_fire;
  logic [OUT_W-1:0]        int_din;
  logic                    cmb_v   [STAGES+1];
  logic [OUT_W-1:0]        cmb_d   [STAGES+1];
  logic                    cmb_lv;
  logic [OUT_W-1:0]        cmb_ld;

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero
  // A write lands at the edge that sees ack high, so a request dropped before ack changes nothing
  assign wb_hit     = WB_REQ.cyc & WB_REQ.stb & ~ack_r;
  assign wb_wr_ctrl = WB_REQ.cyc & WB_REQ.stb & ack_r & WB_REQ.we & WB_REQ.sel[0] & (WB_REQ.adr == `CICR_REG_CTRL);

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (WB_REQ.adr)
      `CICR_REG_CTRL:
        rd_nxt[`CICR_CTRL_RUN_BIT] = run_r;
      `CICR_REG_STATUS:
      begin
        rd_nxt[`CICR_STAT_INTERP_BIT] = ~IS_DEC;
        rd_nxt[`CICR_STAT_RUN_BIT]    = run_r;
        rd_nxt[`CICR_STAT_BUSY_BIT]   = busy_r;
      end
      `CICR_REG_IN_CNT:
        rd_nxt = in_cnt_r;
      `CICR_REG_OUT_CNT:
        rd_nxt = out_cnt_r;
      `CICR_REG_CONFIG:
      begin
        rd_nxt[`CICR_CFG_RATE_LSB +: 15] = 15'(RATE);
        rd_nxt[`CICR_CFG_STG_LSB +: 6]   = 6'(STAGES);
        rd_nxt[`CICR_CFG_DLY_LSB +: 3]   = 3'(DIFF_DELAY);
        rd_nxt[`CICR_CFG_PIPE_BIT]       = PIPE_COMB;
      end
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else if (CE)
    begin
      ack_r <= wb_hit;
      if (wb_hit && !WB_REQ.we)
        dat_r <= rd_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // Control: run gates the input, clear is a one-cycle flush of filter state
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      run_r <= `CICR_CTRL_RUN_RST;
      clr_r <= 1'b0;
    end
    else if (CE)
    begin
      clr_r <= wb_wr_ctrl & WB_REQ.dat[`CICR_CTRL_CLR_BIT];
      if (wb_wr_ctrl)
        run_r <= WB_REQ.dat[`CICR_CTRL_RUN_BIT];
    end
  end

  // Sample counters; clear also zeroes them
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r))
    begin
      in_cnt_r  <= 32'h0000_0000;
      out_cnt_r <= 32'h0000_0000;
    end
    else if (CE)
    begin
      if (in_fire)
        in_cnt_r <= in_cnt_r + 32'h0000_0001;
      if (out_v_r)
        out_cnt_r <= out_cnt_r + 32'h0000_0001;
    end
  end

  // Interpolator takes one input per R output slots; decimator takes one per cycle
  assign SAMPLE_IN_READY = CE & run_r & ~clr_r & (IS_DEC | ~busy_r);
  assign in_fire         = SAMPLE_IN_VALID & SAMPLE_IN_READY;

  // Integrators run at the high rate: input side for decimator, output side for interpolator
  assign int_fire = IS_DEC ? in_fire : up_act_r;
  assign int_din  = IS_DEC ? sext(SAMPLE_IN)
                           : ((ph_r == '0) ? up_hold_r : '0);

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r))
    begin
      for (int i = 0; i < STAGES; i++)
        integ_r[i] <= '0;
    end
    else if (CE && int_fire)
    begin
      integ_r[0] <= integ_r[0] + int_din;
      for (int i = 1; i < STAGES; i++)
        integ_r[i] <= integ_r[i] + integ_r[i-1];
    end
  end

  // Phase counter: input count in the decimator, output slot in the interpolator
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r))
      ph_r <= '0;
    else if (CE && int_fire)
      ph_r <= (ph_r == PH_LAST) ? '0 : ph_r + PH_W'(1);
  end

  // Comb chain input: subsampled last integrator, or the input itself
  assign cmb_v[0] = IS_DEC ? (in_fire && ph_r == PH_LAST) : in_fire;
  assign cmb_d[0] = IS_DEC ? integ_r[STAGES-1] : sext(SAMPLE_IN);

  // Combs run at the low rate, so a delay of M low-rate words spans R*M high-rate samples
  generate
    for (genvar g = 0; g < STAGES; g++)
    begin : g_comb
      cicr_comb #(
        .W    (OUT_W),
        .DLY  (DIFF_DELAY),
        .PIPE (PIPE_COMB)
      ) u_comb (
        .clk       (SYS_CLK),
        .srst      (SRST),
        .ce        (CE),
        .clr       (clr_r),
        .in_valid  (cmb_v[g]),
        .in_data   (cmb_d[g]),
        .out_valid (cmb_v[g+1]),
        .out_data  (cmb_d[g+1])
      );
    end
  endgenerate

  assign cmb_lv = cmb_v[STAGES];
  assign cmb_ld = cmb_d[STAGES];

  // Up-sampler: busy from input accept until the last of the R slots is issued
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r) || IS_DEC)
    begin
      busy_r    <= 1'b0;
      up_act_r  <= 1'b0;
      up_hold_r <= '0;
    end
    else if (CE)
    begin
      if (in_fire)
        busy_r <= 1'b1;
      if (cmb_lv)
      begin
        up_hold_r <= cmb_ld;
        up_act_r  <= 1'b1;
      end
      else if (up_act_r && ph_r == PH_LAST)
      begin
        up_act_r <= 1'b0;
        busy_r   <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r))
      fire_d_r <= 1'b0;
    else if (CE)
      fire_d_r <= up_act_r;
  end

  // Output register: one word per low-rate period (decimator) or per slot (interpolator)
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST || (CE && clr_r))
    begin
      out_r   <= '0;
      out_v_r <= 1'b0;
    end
    else if (CE)
    begin
      if (IS_DEC)
      begin
        out_v_r <= cmb_lv;
        if (cmb_lv)
          out_r <= cmb_ld;
      end
      else
      begin
        out_v_r <= fire_d_r;
        if (fire_d_r)
          out_r <= integ_r[STAGES-1];
      end
    end
  end

  assign SAMPLE_OUT       = out_r;
  assign SAMPLE_OUT_VALID = out_v_r & CE;

endmodule : cicr_filter

// [rtl/cicr_map.svh]
// Register offsets, field positions, reset values and default configuration of the CIC rate changer
`ifndef CICR_MAP_SVH
`define CICR_MAP_SVH

`define CICR_ADR_W          8
`define CICR_REG_CTRL       8'h00
`define CICR_REG_STATUS     8'h04
`define CICR_REG_IN_CNT     8'h08
`define CICR_REG_OUT_CNT    8'h0C
`define CICR_REG_CONFIG     8'h10

`define CICR_CTRL_RUN_BIT   0
`define CICR_CTRL_CLR_BIT   1
`define CICR_CTRL_RUN_RST   1'h1

`define CICR_STAT_INTERP_BIT 0
`define CICR_STAT_RUN_BIT    1
`define CICR_STAT_BUSY_BIT   2

`define CICR_CFG_RATE_LSB   0
`define CICR_CFG_STG_LSB    16
`define CICR_CFG_DLY_LSB    24
`define CICR_CFG_PIPE_BIT   28

`define CICR_IN_W_DEF       16
`define CICR_IN_BP_DEF      15
`define CICR_RATE_DEF       8
`define CICR_STAGES_DEF     3
`define CICR_DLY_DEF        1
`define CICR_PIPE_DEF       1

`endif

// [rtl/cicr_pkg.sv]
// Types shared by the CIC rate changer files
package cicr_pkg;

  typedef enum logic [1:0]
  {
    CICR_DECIM  = 2'h1,
    CICR_INTERP = 2'h2
  } cicr_type_t;

  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } cicr_wb_req_t;

endpackage : cicr_pkg
